// ==== src/stc_pkg.sv ====
// shared constants for the synthesizer tuning and detector control block
package stc_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 24;
  localparam int BAND_W = 8;
  localparam logic [4:0] FRAME_BITS = 5'd31;
  localparam logic [4:0] RD_LOAD_BIT = 5'd7;

  localparam logic [5:0] OFS_INT_DIV   = 6'h03;
  localparam logic [5:0] OFS_FRAC_DIV  = 6'h04;
  localparam logic [5:0] OFS_MOD_MODE  = 6'h06;
  localparam logic [5:0] OFS_REF_BUF   = 6'h08;
  localparam logic [5:0] OFS_CP_CFG    = 6'h09;
  localparam logic [5:0] OFS_CAL_CFG   = 6'h0a;
  localparam logic [5:0] OFS_PD_CTRL   = 6'h0b;
  localparam logic [5:0] OFS_VCO_BAND  = 6'h15;
  localparam logic [5:0] OFS_OUT_DIVG  = 6'h16;
  localparam logic [5:0] OFS_OUT_CTRL  = 6'h17;

  localparam int CAL_DISABLE_BIT = 11;
  localparam int FRAC_MODE_BIT   = 11;
  localparam int REF_HF_BIT      = 21;
  localparam int CP_DN_GAIN_LSB  = 0;
  localparam int CP_UP_GAIN_LSB  = 7;
  localparam int CP_OFS_LSB      = 14;
  localparam int CP_GAIN_W       = 7;
  localparam int CP_OFS_UP_BIT   = 21;
  localparam int CP_OFS_DN_BIT   = 22;
  localparam int PD_UP_EN_BIT    = 5;
  localparam int PD_DN_EN_BIT    = 6;
  localparam int DETECTOR_FORCE_UP_BIT = 9;
  localparam int DETECTOR_FORCE_DOWN_BIT = 10;
  localparam int AUTO_MUTE_BIT   = 7;
  localparam int OUT_DIV_LSB     = 0;
  localparam int OUT_DIV_W       = 6;
  localparam int OUT_GAIN_LSB    = 6;
  localparam int OUT_GAIN_W      = 5;
  localparam int BAND_LSB        = 1;
  localparam int MEAS_N_LSB      = 0;
  localparam int MEAS_N_W        = 3;

  localparam logic [23:0] RST_ZERO    = 24'h000000;
  localparam logic [23:0] RST_PD_CTRL = 24'h000060;
  localparam logic [23:0] RST_OUT_DIV = 24'h000001;
  localparam logic [15:0] CAL_BASE_CYCLES = 16'h0010;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_MEAS = 2'b01,
    CAL_DONE = 2'b11
  } stc_cal_state_type;
endpackage

// ==== src/stc_serial_port.sv ====
// main serial port: 31-bit frames, write committed at frame end
`timescale 1ns/100ps
module stc_serial_port
  import stc_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire logic              sen,
  input  wire logic              sck,
  input  wire logic              sdi,
  input  wire logic [DATA_W-1:0] rd_data,
  output logic [ADDR_W-1:0]      rd_addr,
  output logic                   sdo,
  output logic                   wr_stb,
  output logic [ADDR_W-1:0]      wr_addr,
  output logic [DATA_W-1:0]      wr_data
);
  logic        sck_q;
  logic        sen_q;
  logic [30:0] shift_q;
  logic [4:0]  cnt_q;
  logic [23:0] rd_sh_q;
  wire         sck_rise = sen & sck & ~sck_q;
  wire         sck_fall = sen & ~sck & sck_q;
  wire         frame_end = sen_q & ~sen;
  wire         full_frame = (cnt_q == FRAME_BITS) & ~shift_q[30];
  wire         rd_load = sck_fall & (cnt_q == RD_LOAD_BIT) & shift_q[6];

  assign rd_addr = shift_q[5:0];
  assign sdo     = rd_sh_q[23];

  always_ff @(posedge clock) begin
    if (!rstn) begin
      sck_q <= 1'b0;
      sen_q <= 1'b0;
    end else begin
      sck_q <= sck;
      sen_q <= sen;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn || !sen) begin
      cnt_q   <= 5'd0;
      shift_q <= 31'd0;
    end else if (sck_rise && cnt_q != FRAME_BITS) begin
      cnt_q   <= cnt_q + 5'd1;
      shift_q <= {shift_q[29:0], sdi};
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      rd_sh_q <= 24'h000000;
    end else if (rd_load) begin
      rd_sh_q <= rd_data;
    end else if (sck_fall) begin
      rd_sh_q <= {rd_sh_q[22:0], 1'b0};
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      wr_stb  <= 1'b0;
      wr_addr <= 6'h00;
      wr_data <= 24'h000000;
    end else begin
      wr_stb <= frame_end & full_frame;
      if (frame_end) begin
        wr_addr <= shift_q[29:24];
        wr_data <= shift_q[23:0];
      end
    end
  end
endmodule

// ==== src/stc_vco_cal.sv ====
// vco band calibration sequencer, restartable on each new request
`timescale 1ns/100ps
module stc_vco_cal
  import stc_pkg::*;
#(
  parameter logic [15:0] BASE_CYCLES = CAL_BASE_CYCLES
) (
  input  wire logic                clock,
  input  wire logic                rstn,
  input  wire logic                start,
  input  wire logic [MEAS_N_W-1:0] meas_n,
  input  wire logic [BAND_W-1:0]   band_found,
  output logic                     busy,
  output logic                     done,
  output logic [BAND_W-1:0]        band_out
);
  stc_cal_state_type state_q;
  logic [15:0]       cnt_q;
  wire  [15:0]       meas_len = BASE_CYCLES << meas_n;
  wire               meas_end = (cnt_q == meas_len - 16'd1);

  assign busy = (state_q == CAL_MEAS);
  assign done = (state_q == CAL_DONE);

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_q  <= CAL_IDLE;
      cnt_q    <= 16'h0000;
      band_out <= 8'h00;
    end else if (start) begin
      state_q <= CAL_MEAS;
      cnt_q   <= 16'h0000;
    end else begin
      unique case (state_q)
        CAL_IDLE: state_q <= CAL_IDLE;
        CAL_MEAS: begin
          cnt_q <= cnt_q + 16'd1;
          if (meas_end) begin
            state_q  <= CAL_DONE;
            band_out <= band_found;
          end
        end
        CAL_DONE: state_q <= CAL_IDLE;
        default:  state_q <= CAL_IDLE;
      endcase
    end
  end
endmodule

// ==== src/stc_synth_ctrl.sv ====
// synthesizer tuning, output mute and phase detector control top
// Functional notes
// - fractional write calibrates first, then loads modulator
// - calibration off: fractional loads at once
// - integer mode: integer write calibrates then prescales
// - output divider zero mutes output while it stays zero
// - auto mute during calibration when enabled
// - output gain from divider register bits 10:6
// - charge pump up, down gain and offset fields
// - offset direction bits enable up, down offset
// - up enable clear masks detector up output
// - down mask; both masked tri-states pump
// - force bits drive pump continuously up/down
// - reference buffer mode from bit 21
// - calibrated band readable in band register 8:1
`timescale 1ns/100ps
module stc_synth_ctrl
  import stc_pkg::*;
#(
  parameter logic [15:0] CAL_BASE = CAL_BASE_CYCLES
) (
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire logic              sen,
  input  wire logic              sck,
  input  wire logic              sdi,
  output logic                   sdo,
  input  wire logic              pd_up_raw,
  input  wire logic              pd_dn_raw,
  input  wire logic [BAND_W-1:0] band_found,
  output logic [DATA_W-1:0]      prescaler_int,
  output logic [DATA_W-1:0]      modulator_frac,
  output logic [BAND_W-1:0]      vco_band,
  output logic                   cal_busy,
  output logic                   output_mute,
  output logic [OUT_DIV_W-1:0]   out_div,
  output logic [OUT_GAIN_W-1:0]  out_gain,
  output logic [CP_GAIN_W-1:0]   cp_up_gain,
  output logic [CP_GAIN_W-1:0]   cp_dn_gain,
  output logic [CP_GAIN_W-1:0]   cp_offset,
  output logic                   cp_offset_up_en,
  output logic                   cp_offset_dn_en,
  output logic                   pd_up_out,
  output logic                   pd_dn_out,
  output logic                   cp_tristate,
  output logic                   ref_buf_high_freq
);
  logic [DATA_W-1:0] int_q;
  logic [DATA_W-1:0] frac_q;
  logic [DATA_W-1:0] mode_q;
  logic [DATA_W-1:0] ref_q;
  logic [DATA_W-1:0] cp_q;
  logic [DATA_W-1:0] calcfg_q;
  logic [DATA_W-1:0] pd_q;
  logic [DATA_W-1:0] band_reg_q;
  logic [DATA_W-1:0] divg_q;
  logic [DATA_W-1:0] outc_q;
  logic [DATA_W-1:0] presc_q;
  logic [DATA_W-1:0] dsm_q;
  logic [BAND_W-1:0] vco_band_q;
  logic              pend_frac_q;
  logic              pend_int_q;
  logic              mute_q;
  logic              pd_up_q;
  logic              pd_dn_q;
  logic              tri_q;

  logic              wr_stb;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic              cal_done;
  logic [BAND_W-1:0] cal_band;

  stc_serial_port u_port (
    .clock   (clock),
    .rstn    (rstn),
    .sen     (sen),
    .sck     (sck),
    .sdi     (sdi),
    .rd_data (rd_data),
    .rd_addr (rd_addr),
    .sdo     (sdo),
    .wr_stb  (wr_stb),
    .wr_addr (wr_addr),
    .wr_data (wr_data)
  );

  // write decode
  wire wr_int   = wr_stb & (wr_addr == OFS_INT_DIV);
  wire wr_frac  = wr_stb & (wr_addr == OFS_FRAC_DIV);
  wire wr_band  = wr_stb & (wr_addr == OFS_VCO_BAND);
  wire cal_en   = ~calcfg_q[CAL_DISABLE_BIT];
  wire frac_md  = mode_q[FRAC_MODE_BIT];
  wire int_go   = wr_int & ~frac_md;
  wire cal_start = cal_en & (wr_frac | int_go);
  wire up_en    = pd_q[PD_UP_EN_BIT];
  wire dn_en    = pd_q[PD_DN_EN_BIT];
  wire force_up = pd_q[DETECTOR_FORCE_UP_BIT];
  wire force_dn = pd_q[DETECTOR_FORCE_DOWN_BIT];
  wire auto_mute = outc_q[AUTO_MUTE_BIT];
  wire div_zero = (divg_q[OUT_DIV_LSB +: OUT_DIV_W] == 6'h00);

  stc_vco_cal #(
    .BASE_CYCLES (CAL_BASE)
  ) u_cal (
    .clock      (clock),
    .rstn       (rstn),
    .start      (cal_start),
    .meas_n     (calcfg_q[MEAS_N_LSB +: MEAS_N_W]),
    .band_found (band_found),
    .busy       (cal_busy),
    .done       (cal_done),
    .band_out   (cal_band)
  );

  // read mux
  wire [DATA_W-1:0] band_rd = {band_reg_q[23:9], vco_band_q, band_reg_q[0]};
  assign rd_data = (rd_addr == OFS_INT_DIV)  ? int_q :
                   (rd_addr == OFS_FRAC_DIV) ? frac_q :
                   (rd_addr == OFS_MOD_MODE) ? mode_q :
                   (rd_addr == OFS_REF_BUF)  ? ref_q :
                   (rd_addr == OFS_CP_CFG)   ? cp_q :
                   (rd_addr == OFS_CAL_CFG)  ? calcfg_q :
                   (rd_addr == OFS_PD_CTRL)  ? pd_q :
                   (rd_addr == OFS_VCO_BAND) ? band_rd :
                   (rd_addr == OFS_OUT_DIVG) ? divg_q :
                   (rd_addr == OFS_OUT_CTRL) ? outc_q : 24'h000000;

  // register file
  always_ff @(posedge clock) begin
    if (!rstn) begin
      int_q      <= RST_ZERO;
      frac_q     <= RST_ZERO;
      mode_q     <= RST_ZERO;
      ref_q      <= RST_ZERO;
      cp_q       <= RST_ZERO;
      calcfg_q   <= RST_ZERO;
      pd_q       <= RST_PD_CTRL;
      band_reg_q <= RST_ZERO;
      divg_q     <= RST_OUT_DIV;
      outc_q     <= RST_ZERO;
    end else if (wr_stb) begin
      unique case (wr_addr)
        OFS_INT_DIV:  int_q      <= wr_data;
        OFS_FRAC_DIV: frac_q     <= wr_data;
        OFS_MOD_MODE: mode_q     <= wr_data;
        OFS_REF_BUF:  ref_q      <= wr_data;
        OFS_CP_CFG:   cp_q       <= wr_data;
        OFS_CAL_CFG:  calcfg_q   <= wr_data;
        OFS_PD_CTRL:  pd_q       <= wr_data;
        OFS_VCO_BAND: band_reg_q <= wr_data;
        OFS_OUT_DIVG: divg_q     <= wr_data;
        OFS_OUT_CTRL: outc_q     <= wr_data;
        default:      int_q      <= int_q;
      endcase
    end
  end

  // divider loads, direct or after calibration
  always_ff @(posedge clock) begin
    if (!rstn) begin
      presc_q     <= RST_ZERO;
      dsm_q       <= RST_ZERO;
      pend_frac_q <= 1'b0;
      pend_int_q  <= 1'b0;
    end else if (cal_start) begin
      pend_frac_q <= wr_frac;
      pend_int_q  <= int_go;
    end else if (wr_frac) begin
      dsm_q   <= wr_data;
      presc_q <= int_q;
    end else if (int_go && !cal_en) begin
      presc_q <= wr_data;
    end else if (cal_done) begin
      if (pend_frac_q) begin
        dsm_q <= frac_q;
      end
      if (pend_frac_q || pend_int_q) begin
        presc_q <= int_q;
      end
      pend_frac_q <= 1'b0;
      pend_int_q  <= 1'b0;
    end
  end

  // band: manual write when calibration off, else calibration result
  always_ff @(posedge clock) begin
    if (!rstn) begin
      vco_band_q <= 8'h00;
    end else if (cal_done) begin
      vco_band_q <= cal_band;
    end else if (wr_band && !cal_en) begin
      vco_band_q <= wr_data[BAND_LSB +: BAND_W];
    end
  end

  // mute and detector outputs
  always_ff @(posedge clock) begin
    if (!rstn) begin
      mute_q  <= 1'b1;
      pd_up_q <= 1'b0;
      pd_dn_q <= 1'b0;
      tri_q   <= 1'b0;
    end else begin
      mute_q  <= div_zero | (auto_mute & cal_busy);
      pd_up_q <= (pd_up_raw & up_en) | force_up;
      pd_dn_q <= (pd_dn_raw & dn_en) | force_dn;
      tri_q   <= ~up_en & ~dn_en & ~force_up & ~force_dn;
    end
  end

  assign prescaler_int     = presc_q;
  assign modulator_frac    = dsm_q;
  assign vco_band          = vco_band_q;
  assign output_mute       = mute_q;
  assign out_div           = divg_q[OUT_DIV_LSB +: OUT_DIV_W];
  assign out_gain          = divg_q[OUT_GAIN_LSB +: OUT_GAIN_W];
  assign cp_up_gain        = cp_q[CP_UP_GAIN_LSB +: CP_GAIN_W];
  assign cp_dn_gain        = cp_q[CP_DN_GAIN_LSB +: CP_GAIN_W];
  assign cp_offset         = cp_q[CP_OFS_LSB +: CP_GAIN_W];
  assign cp_offset_up_en   = cp_q[CP_OFS_UP_BIT];
  assign cp_offset_dn_en   = cp_q[CP_OFS_DN_BIT];
  assign pd_up_out         = pd_up_q;
  assign pd_dn_out         = pd_dn_q;
  assign cp_tristate       = tri_q;
  assign ref_buf_high_freq = ref_q[REF_HF_BIT];

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  sequence s_frac_launch;
    wr_frac && cal_en;
  endsequence
  sequence s_modulator_held;
    cal_busy && $stable(dsm_q);
  endsequence

  property p_frac_after_cal;
    s_frac_launch |=> s_modulator_held;
  endproperty
  a_frac_after_cal: assert property (p_frac_after_cal)
    else $error("modulator changed before calibration ended");

  property p_frac_direct;
    wr_frac && !cal_en |=> dsm_q == $past(wr_data) && !cal_busy;
  endproperty
  a_frac_direct: assert property (p_frac_direct)
    else $error("direct fractional load missing");

  property p_int_direct;
    int_go && !cal_en |=> presc_q == $past(wr_data) && $stable(vco_band_q);
  endproperty
  a_int_direct: assert property (p_int_direct)
    else $error("direct integer load missing");

  property p_band_result;
    cal_done |=> vco_band_q == $past(cal_band) && !cal_busy;
  endproperty
  a_band_result: assert property (p_band_result)
    else $error("calibrated band not captured");

  property p_div_zero_mute;
    div_zero ##1 div_zero |-> output_mute;
  endproperty
  a_div_zero_mute: assert property (p_div_zero_mute)
    else $error("output not muted with divider zero");

  property p_auto_mute;
    auto_mute && cal_busy |=> output_mute;
  endproperty
  a_auto_mute: assert property (p_auto_mute)
    else $error("output not muted during calibration");

  property p_up_mask;
    !up_en && !force_up |=> !pd_up_out;
  endproperty
  a_up_mask: assert property (p_up_mask)
    else $error("detector up output not masked");

  property p_tristate;
    !up_en && !dn_en && !force_up && !force_dn |=> cp_tristate && !pd_dn_out;
  endproperty
  a_tristate: assert property (p_tristate)
    else $error("pump not tri-stated with both masked");

  property p_force_dn;
    force_dn [*2] |-> pd_dn_out;
  endproperty
  a_force_dn: assert property (p_force_dn)
    else $error("force down not applied");

  property p_write_on_frame;
    wr_stb |-> $past(sen, 2) && !$past(sen);
  endproperty
  a_write_on_frame: assert property (p_write_on_frame)
    else $error("write taken before frame end");
endmodule

// ==== sim/stc_host_model.sv ====
// host controller model driving the main serial port
`timescale 1ns/100ps
module stc_host_model
  import stc_pkg::*;
(
  input  wire logic clock,
  output logic      sen,
  output logic      sck,
  output logic      sdi,
  input  wire logic sdo
);
  initial begin
    sen = 1'b0;
    sck = 1'b0;
    sdi = 1'b0;
  end

  // one bit: sck low two clocks, sdo taken late in the low phase, then high three clocks
  task automatic send_bit(input logic b, output logic seen);
    @(negedge clock);
    sck = 1'b0;
    sdi = b;
    repeat (2) @(negedge clock);
    seen = sdo;
    sck = 1'b1;
    repeat (2) @(negedge clock);
  endtask

  // rw, address, data msb first; nbits below 31 gives a cut frame
  task automatic frame(input logic rw, input logic [ADDR_W-1:0] addr,
                       input logic [DATA_W-1:0] data, input int nbits,
                       output logic [DATA_W-1:0] rdata);
    logic [30:0] word;
    logic        seen;
    word = {rw, addr, data};
    rdata = 24'h000000;
    @(negedge clock);
    sen = 1'b1;
    for (int i = 0; i < nbits; i++) begin
      send_bit(word[30-i], seen);
      if (i >= 7) rdata[30-i] = seen;
    end
    @(negedge clock);
    sen = 1'b0;
    sck = 1'b0;
    sdi = ~sdi;
    repeat (2) @(negedge clock);
  endtask
endmodule

// ==== sim/tb_top.sv ====
// self-checking bench for the synthesizer tuning and detector control block
`timescale 1ns/100ps
module tb_top
  import stc_pkg::*;
();
  localparam logic [15:0] CAL_LEN = 16'h0008;
  logic                  clock = 1'b0;
  logic                  rstn  = 1'b0;
  logic                  sen, sck, sdi, sdo, pd_up_raw, pd_dn_raw;
  logic [BAND_W-1:0]     band_found, vco_band;
  logic [DATA_W-1:0]     prescaler_int, modulator_frac, rd;
  logic                  cal_busy, output_mute, cp_offset_up_en, cp_offset_dn_en;
  logic [OUT_DIV_W-1:0]  out_div;
  logic [OUT_GAIN_W-1:0] out_gain;
  logic [CP_GAIN_W-1:0]  cp_up_gain, cp_dn_gain, cp_offset;
  logic                  pd_up_out, pd_dn_out, cp_tristate, ref_buf_high_freq;
  logic                  busy_seen = 1'b0;
  logic [DATA_W-1:0]     cp_vals [3] = '{24'h000000, 24'h267264, 24'h543264};
  int                    fails = 0;
  int                    checked = 0;

  always #20 clock = ~clock;
  always @(posedge clock) if (cal_busy === 1'b1) busy_seen <= 1'b1;

  stc_synth_ctrl #(.CAL_BASE(CAL_LEN)) uut (
    .clock(clock), .rstn(rstn), .sen(sen), .sck(sck), .sdi(sdi), .sdo(sdo),
    .pd_up_raw(pd_up_raw), .pd_dn_raw(pd_dn_raw), .band_found(band_found),
    .prescaler_int(prescaler_int), .modulator_frac(modulator_frac),
    .vco_band(vco_band), .cal_busy(cal_busy), .output_mute(output_mute),
    .out_div(out_div), .out_gain(out_gain), .cp_up_gain(cp_up_gain),
    .cp_dn_gain(cp_dn_gain), .cp_offset(cp_offset),
    .cp_offset_up_en(cp_offset_up_en), .cp_offset_dn_en(cp_offset_dn_en),
    .pd_up_out(pd_up_out), .pd_dn_out(pd_dn_out), .cp_tristate(cp_tristate),
    .ref_buf_high_freq(ref_buf_high_freq)
  );

  stc_host_model host (.clock(clock), .sen(sen), .sck(sck), .sdi(sdi), .sdo(sdo));

  task automatic check(input string what, input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    host.frame(1'b0, a, d, 31, rd);
    repeat (2) @(negedge clock);
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    host.frame(1'b1, a, 24'h000000, 31, rd);
    check($sformatf("reg %h", a), rd, exp);
  endtask

  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (cal_busy !== lvl && n < 500) begin
      @(negedge clock);
      n++;
    end
    if (n >= 500) begin
      fails++;
      $display("FAIL cal_busy wait expected %b seen %b", lvl, cal_busy);
      finish_test();
    end
  endtask

  task automatic pd_case(input logic [DATA_W-1:0] ctrl, input logic up, input logic dn,
                         input logic eu, input logic ed, input logic et);
    pd_up_raw = up;
    pd_dn_raw = dn;
    wr(OFS_PD_CTRL, ctrl);
    check("pd_up_out", pd_up_out, eu);
    check("pd_dn_out", pd_dn_out, ed);
    check("cp_tristate", cp_tristate, et);
  endtask

  initial begin
    pd_up_raw = 1'b1;
    pd_dn_raw = 1'b1;
    band_found = 8'h00;
    repeat (10) @(negedge clock);
    rstn = 1'b1;
    repeat (2) @(negedge clock);
    check("output_mute", output_mute, 24'h0);
    rd_chk(OFS_PD_CTRL, 24'h000060);
    rd_chk(OFS_OUT_DIVG, 24'h000001);
    rd_chk(6'h3f, 24'h000000);
    host.frame(1'b0, OFS_OUT_DIVG, 24'h000000, 20, rd);
    host.frame(1'b1, OFS_OUT_DIVG, 24'h000000, 31, rd);
    check("out_div", out_div, 24'h1);
    $display("test reset_and_refused done");

    wr(OFS_OUT_DIVG, 24'h000540);
    check("out_gain", out_gain, 24'h15);
    check("out_div", out_div, 24'h0);
    check("output_mute", output_mute, 24'h1);
    wr(OFS_OUT_DIVG, 24'h0007c2);
    check("out_gain", out_gain, 24'h1f);
    check("output_mute", output_mute, 24'h0);
    $display("test output done");

    foreach (cp_vals[i]) begin
      wr(OFS_CP_CFG, cp_vals[i]);
      check("cp_up_gain", cp_up_gain, cp_vals[i][13:7]);
      check("cp_dn_gain", cp_dn_gain, cp_vals[i][6:0]);
      check("cp_offset", cp_offset, cp_vals[i][20:14]);
      check("cp_offset_up_en", cp_offset_up_en, cp_vals[i][21]);
      check("cp_offset_dn_en", cp_offset_dn_en, cp_vals[i][22]);
    end
    $display("test charge_pump done");

    pd_case(24'h000060, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    pd_case(24'h000060, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
    pd_case(24'h000040, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    pd_case(24'h000020, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    pd_case(24'h000000, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    pd_case(24'h000200, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    pd_case(24'h000400, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    wr(OFS_REF_BUF, 24'h200000);
    check("ref_buf_high_freq", ref_buf_high_freq, 24'h1);
    wr(OFS_REF_BUF, 24'h000000);
    check("ref_buf_high_freq", ref_buf_high_freq, 24'h0);
    $display("test detector_and_reference done");

    band_found = 8'h3c;
    wr(OFS_CAL_CFG, 24'h000800);
    wr(OFS_VCO_BAND, 24'h0000b4);
    check("vco_band", vco_band, 24'h5a);
    wr(OFS_INT_DIV, 24'h000064);
    check("prescaler_int", prescaler_int, 24'h000064);
    wr(OFS_MOD_MODE, 24'h000800);
    wr(OFS_FRAC_DIV, 24'h123456);
    check("modulator_frac", modulator_frac, 24'h123456);
    check("vco_band", vco_band, 24'h5a);
    check("busy_seen", busy_seen, 24'h0);
    $display("test manual_tuning done");

    band_found = 8'ha5;
    wr(OFS_OUT_CTRL, 24'h000080);
    wr(OFS_CAL_CFG, 24'h000000);
    wr(OFS_CP_CFG, 24'h003264);
    wr(OFS_INT_DIV, 24'h000032);
    check("prescaler_int", prescaler_int, 24'h000064);
    wr(OFS_FRAC_DIV, 24'h0abcde);
    check("cal_busy", cal_busy, 24'h1);
    check("output_mute", output_mute, 24'h1);
    check("modulator_frac", modulator_frac, 24'h123456);
    wait_busy(1'b0);
    repeat (3) @(negedge clock);
    check("modulator_frac", modulator_frac, 24'h0abcde);
    check("prescaler_int", prescaler_int, 24'h000032);
    check("vco_band", vco_band, 24'ha5);
    check("output_mute", output_mute, 24'h0);
    rd_chk(OFS_VCO_BAND, 24'h00014a);
    wr(OFS_CP_CFG, 24'h267264);
    $display("test fractional_calibration done");

    wr(OFS_MOD_MODE, 24'h000000);
    wr(OFS_CP_CFG, 24'h003264);
    band_found = 8'h33;
    wr(OFS_INT_DIV, 24'h000040);
    check("cal_busy", cal_busy, 24'h1);
    check("prescaler_int", prescaler_int, 24'h000032);
    wait_busy(1'b0);
    repeat (3) @(negedge clock);
    check("prescaler_int", prescaler_int, 24'h000040);
    check("vco_band", vco_band, 24'h33);
    $display("test integer_calibration done");
    finish_test();
  end
endmodule
